// >>> design/host_port_pkg.sv
package host_port_pkg;
	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h07;     // mask / pending bit location
	localparam logic [7:0] ADDR_SOFT_RESET = 8'h08;     // software reset location
	localparam logic [7:0] ADDR_LAST_REG   = 8'h08;     // highest decoded location
	localparam int         BIT_PENDING     = 2;         // pending/mask bit position
	localparam int         BIT_SOFT_RESET  = 0;         // software reset bit position
	localparam logic [7:0] MASK_RESET_VAL  = 8'h00;     // mask blocks after reset

	// ----------------------------------------
	// host side apb register map
	// ----------------------------------------
	localparam logic [11:0] APB_CMD    = 12'h000;       // [7:0] addr [15:8] data [16] rd [17] go
	localparam logic [11:0] APB_STAT   = 12'h004;       // [0] busy [15:8] read data [16] irq
	localparam logic [11:0] APB_CFG    = 12'h008;       // [1:0] bus style
	localparam logic [11:0] APB_ISTAT  = 12'h00c;       // [0] done [1] irq, clear on read
	localparam logic [11:0] APB_IMASK  = 12'h010;       // same layout as istat

	// ----------------------------------------
	// bus styles and host timing
	// ----------------------------------------
	typedef enum logic [1:0] {
		STYLE_STROBE = 2'b00,                            // strobe and direction
		STYLE_RDWR   = 2'b01,                            // separate read/write strobes
		STYLE_MUX    = 2'b10                             // multiplexed address/data
	} bus_style_t;

	localparam int         PHASE_NS     = 40;           // host phase length
	localparam int         CLK_NS       = 4;            // mclk period
	localparam logic [4:0] PHASE_CYCLES = 5'((PHASE_NS + CLK_NS - 1) / CLK_NS);
endpackage

// >>> design/host_port_if.sv
`timescale 1ns/10ps
interface host_port_if;
	logic [7:0] ad_o;      // host drive of shared/data lines
	logic       ad_oe;     // host drives data lines
	logic [7:0] ad_dev_o;  // device drive of data lines
	logic       ad_dev_oe; // device drives data lines
	logic [7:0] addr;      // separate address bus
	logic       cs_n;      // chip select, active low
	logic       rd_n;      // read strobe / direction (high = read)
	logic       wr_n;      // write strobe
	logic       data_strobe_n; // data strobe
	logic       ale;       // address latch / style select
	logic       int_oe;    // device pulls interrupt low
	wire  [7:0] ad   = ad_oe ? ad_o : (ad_dev_oe ? ad_dev_o : 8'hff);
	wire        int_n = ~int_oe;

	modport device (input ad, addr, cs_n, rd_n, wr_n, data_strobe_n, ale,
		output ad_dev_o, ad_dev_oe, int_oe);
	modport host (input ad, int_n, output ad_o, ad_oe, addr, cs_n, rd_n, wr_n, data_strobe_n, ale);
endinterface

// >>> design/host_port_device.sv
`timescale 1ns/10ps
module host_port_device
	import host_port_pkg::*;
(
	input  wire logic mclk_i,       // system clock
	input  wire logic rst_n_i,      // async reset, active low
	host_port_if.device bus,        // host pins
	input  wire logic irq_event_i,  // internal interrupt request pulse
	output logic      soft_rst_o,   // internal reset pulse
	output logic [1:0] style_o      // current bus style
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// strobe-and-direction style test, shared by every strobe decode
	function automatic logic strobe_style(input bus_style_t s);
		return s == STYLE_STROBE;
	endfunction
	// end of an active-low strobe between two settled samples
	function automatic logic strobe_end(input logic now_n, input logic was_n);
		return now_n && !was_n;
	endfunction

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	localparam logic [4:0] CTL_IDLE = 5'h1f; // every control pin inactive
	logic [7:0] ad_s1;    // shared lines, first stage
	logic [7:0] ad_s2;    // shared lines, settled
	logic [7:0] addr_s1;  // address bus, first stage
	logic [7:0] addr_s2;  // address bus, settled
	logic [4:0] ctl_s1;   // control pins, first stage
	logic [4:0] ctl_s2;   // control pins, settled
	logic [4:0] ctl_prev; // settled control pins, one cycle late
	// two flops on every host pin before any logic reads it
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ad_s1    <= 8'h00;
			ad_s2    <= 8'h00;
			addr_s1  <= 8'h00;
			addr_s2  <= 8'h00;
			ctl_s1   <= CTL_IDLE;
			ctl_s2   <= CTL_IDLE;
			ctl_prev <= CTL_IDLE;
		end else begin
			ad_s1    <= bus.ad;
			ad_s2    <= ad_s1;
			addr_s1  <= bus.addr;
			addr_s2  <= addr_s1;
			ctl_s1   <= {bus.ale, bus.data_strobe_n, bus.wr_n, bus.rd_n, bus.cs_n};
			ctl_s2   <= ctl_s1;
			ctl_prev <= ctl_s2;
		end
	end
	// settled control pins by name
	wire cs_n = ctl_s2[0];
	wire rd_n = ctl_s2[1];
	wire wr_n = ctl_s2[2];
	wire ds_n = ctl_s2[3];
	wire ale  = ctl_s2[4];
	wire ale_prev = ctl_prev[4];

	// ----------------------------------------
	// bus style selection
	// ----------------------------------------
	logic mux_reg;     // multiplexed style locked
	logic started_reg; // first cycle out of reset has passed
	wire  ale_edge = started_reg && (ale != ale_prev);
	// any latch edge locks multiplexed style
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mux_reg     <= 1'b0;
			started_reg <= 1'b0;
		end else begin
			started_reg <= 1'b1;
			if (ale_edge)
				mux_reg <= 1'b1;                          // sticky, hardware reset only
		end
	end
	// style follows the settled latch pin until the lock
	wire bus_style_t style = mux_reg ? STYLE_MUX : (ale ? STYLE_STROBE : STYLE_RDWR);
	assign style_o = style;

	// ----------------------------------------
	// address capture and decode
	// ----------------------------------------
	logic [7:0] lat_addr_reg;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			lat_addr_reg <= 8'h00;
		else if (mux_reg && ale)
			lat_addr_reg <= ad_s2;                        // select not needed while latching
	end
	// same decode for either address source
	wire [7:0] eff_addr = (style == STYLE_MUX) ? lat_addr_reg : addr_s2;
	wire       sel_irq  = (eff_addr == ADDR_IRQ_CTRL);
	wire       sel_rst  = (eff_addr == ADDR_SOFT_RESET);

	// ----------------------------------------
	// access detection
	// ----------------------------------------
	// strobe decode per style
	wire strobe_rd = strobe_style(style) ? (!ds_n && rd_n) : !rd_n;
	wire strobe_wr = strobe_style(style) ? (!ds_n && !rd_n) : !wr_n;
	wire active_rd = !cs_n && strobe_rd;
	wire ds_rise   = strobe_end(ds_n, ctl_prev[3]);
	wire wr_rise   = strobe_end(wr_n, ctl_prev[2]);
	// write completes at strobe end; chip select held through it
	wire wr_done   = !cs_n && (strobe_style(style) ? (ds_rise && !rd_n) : wr_rise);
	logic wr_act_reg;
	wire  wr_commit = wr_done && wr_act_reg;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic       mask_reg;    // interrupt mask, zero blocks
	logic       pend_reg;    // interrupt pending
	logic       srst_reg;    // software reset bit
	logic [7:0] rd_data_reg; // registered read value
	wire  [7:0] wdata = ad_s2;
	// decoded register writes
	wire wr_irq    = wr_commit && sel_irq;
	wire wr_rst    = wr_commit && sel_rst;
	wire srst_fall = wr_rst && srst_reg && !wdata[BIT_SOFT_RESET];
	wire pend_ack  = wr_irq && !wdata[BIT_PENDING];  // writing zero acknowledges

	// strobe seen active in the previous cycle
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			wr_act_reg <= 1'b0;
		else
			wr_act_reg <= !cs_n && strobe_wr;
	end

	// software reset bit, untouched by the reset it causes
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			srst_reg <= 1'b0;
		else if (wr_rst)
			srst_reg <= wdata[BIT_SOFT_RESET];
	end

	// one-cycle internal reset when the bit is set then cleared
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			soft_rst_o <= 1'b0;
		else
			soft_rst_o <= srst_fall;
	end

	// mask blocks after either reset
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			mask_reg <= MASK_RESET_VAL[BIT_PENDING];
		else if (soft_rst_o)
			mask_reg <= MASK_RESET_VAL[BIT_PENDING];
		else if (wr_irq)
			mask_reg <= wdata[BIT_PENDING];
	end

	// event sets pending regardless of mask, and beats any clear
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			pend_reg <= 1'b0;
		else if (irq_event_i)
			pend_reg <= 1'b1;
		else if (soft_rst_o || pend_ack)
			pend_reg <= 1'b0;
	end

	// ----------------------------------------
	// read data and interrupt pin
	// ----------------------------------------
	// value of the addressed location, zero elsewhere
	wire [7:0] irq_rd = 8'({7'h00, pend_reg} << BIT_PENDING);
	wire [7:0] rst_rd = 8'({7'h00, srst_reg} << BIT_SOFT_RESET);
	wire [7:0] rd_mux = sel_irq ? irq_rd : (sel_rst ? rst_rd : 8'h00);
	// read data from a flop, lines driven only during a read
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			rd_data_reg <= 8'h00;
		else
			rd_data_reg <= rd_mux;
	end
	assign bus.ad_dev_o  = rd_data_reg;
	assign bus.ad_dev_oe = active_rd;
	assign bus.int_oe    = pend_reg && mask_reg;           // open drain pull low
endmodule

// >>> design/host_port_master.sv
`timescale 1ns/10ps
module host_port_master
	import host_port_pkg::*;
(
	input  wire logic        mclk_i,    // system clock
	input  wire logic        rst_n_i,   // async reset, active low
	input  wire logic        psel,      // apb select
	input  wire logic        penable,   // apb enable
	input  wire logic        pwrite,    // apb direction
	input  wire logic [11:0] paddr,     // apb address
	input  wire logic [31:0] pwdata,    // apb write data
	output logic      [31:0] prdata,    // apb read data
	output logic             pready,    // apb ready
	output logic             pslverr,   // apb error
	output logic             irq_o,     // interrupt to software
	host_port_if.host        bus        // device pins
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000, ST_ADDR = 3'b001, ST_STROBE = 3'b010, ST_END = 3'b011
	} hstate_t;
	hstate_t    state_reg;
	logic [4:0] cnt_reg;
	logic [7:0] a_reg, d_reg, rdat_reg;
	logic       rd_reg, busy_reg;
	logic [1:0] cfg_reg, ist_reg, imask_reg;
	logic [1:0] int_s;

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	wire acc = psel && penable;
	wire go  = acc && pwrite && paddr == APB_CMD && pwdata[17] && !busy_reg;
	wire done_ev = (state_reg == ST_END) && cnt_reg == 5'h00;
	wire int_ev  = !int_s[1];
	assign pready  = 1'b1;
	assign pslverr = 1'b0;
	assign irq_o   = |(ist_reg & imask_reg);
	always_comb begin
		unique case (paddr)
			APB_STAT:  prdata = {15'h0000, !int_s[1], rdat_reg, 7'h00, busy_reg};
			APB_CFG:   prdata = {30'h00000000, cfg_reg};
			APB_ISTAT: prdata = {30'h00000000, ist_reg};
			APB_IMASK: prdata = {30'h00000000, imask_reg};
			default:   prdata = 32'h00000000;
		endcase
	end
	wire ist_clr = acc && !pwrite && paddr == APB_ISTAT;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cfg_reg   <= 2'b00;
			imask_reg <= 2'b00;
			ist_reg   <= 2'b00;
			int_s     <= 2'b11;
		end else begin
			int_s <= {int_s[0], bus.int_n};
			if (acc && pwrite && paddr == APB_CFG)   cfg_reg   <= pwdata[1:0];
			if (acc && pwrite && paddr == APB_IMASK) imask_reg <= pwdata[1:0];
			ist_reg <= (ist_clr ? 2'b00 : ist_reg) | {int_ev, done_ev};  // set beats clear
		end
	end

	// ----------------------------------------
	// pin sequencer, one phase per state
	// ----------------------------------------
	wire bus_style_t style = bus_style_t'(cfg_reg);
	wire strobe_on = state_reg == ST_STROBE;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg <= ST_IDLE;
			cnt_reg   <= 5'h00;
			busy_reg  <= 1'b0;
			a_reg     <= 8'h00;
			d_reg     <= 8'h00;
			rd_reg    <= 1'b0;
			rdat_reg  <= 8'h00;
		end else begin
			if (cnt_reg != 5'h00)
				cnt_reg <= cnt_reg - 5'h01;
			unique case (state_reg)
				ST_IDLE: if (go) begin
					a_reg    <= pwdata[7:0];
					d_reg    <= pwdata[15:8];
					rd_reg   <= pwdata[16];
					busy_reg <= 1'b1;
					cnt_reg  <= PHASE_CYCLES;
					state_reg <= ST_ADDR;
				end
				ST_ADDR: if (cnt_reg == 5'h00) begin
					cnt_reg   <= PHASE_CYCLES;
					state_reg <= ST_STROBE;
				end
				ST_STROBE: if (cnt_reg == 5'h00) begin
					if (rd_reg) rdat_reg <= bus.ad;                // sampled before strobe ends
					cnt_reg   <= PHASE_CYCLES;
					state_reg <= ST_END;
				end
				ST_END: if (cnt_reg == 5'h00) begin
					busy_reg  <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end
	wire sel = state_reg != ST_IDLE;
	assign bus.cs_n          = !(sel && state_reg != ST_ADDR || (sel && style != STYLE_MUX));
	assign bus.ale           = (style == STYLE_STROBE) ? 1'b1 : (style == STYLE_MUX && state_reg == ST_ADDR);
	assign bus.data_strobe_n = !(style == STYLE_STROBE && strobe_on);  // rising edge ends access
	assign bus.rd_n          = (style == STYLE_STROBE) ? rd_reg : !(strobe_on && rd_reg);
	assign bus.wr_n          = !(style != STYLE_STROBE && strobe_on && !rd_reg);
	assign bus.addr          = (style == STYLE_MUX) ? 8'h00 : a_reg;   // whole address bus zero in multiplexed style
	assign bus.ad_o          = (style == STYLE_MUX && state_reg == ST_ADDR) ? a_reg : d_reg;
	assign bus.ad_oe         = sel && ((style == STYLE_MUX && state_reg == ST_ADDR) || !rd_reg);
endmodule

// >>> testbench/host_port_properties.sv
`timescale 1ns/10ps
module host_port_properties (
	input  wire logic       mclk_i,        // clock
	input  wire logic       rst_n_i,       // reset, active low
	input  wire logic       cs_n,          // chip select
	input  wire logic       wr_n,          // write strobe
	input  wire logic       data_strobe_n, // data strobe
	input  wire logic       ale,           // address latch
	input  wire logic       ad_oe,         // host drives lines
	input  wire logic       ad_dev_oe,     // device drives lines
	input  wire logic [7:0] ad             // resolved lines
);
	// ----------------------------------------
	// helper logic
	// ----------------------------------------
	logic [2:0] cs_hi_reg;
	// cycles since chip select went high, saturating
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cs_hi_reg <= 3'h7;
		else if (!cs_n)
			cs_hi_reg <= 3'h0;
		else if (cs_hi_reg != 3'h7)
			cs_hi_reg <= cs_hi_reg + 3'h1;
	end
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	sequence s_wr_held; !wr_n [*8]; endsequence
	sequence s_ds_held; !data_strobe_n [*8]; endsequence
	sequence s_cs_held; !cs_n [*8]; endsequence
	property p_one_driver; !(ad_oe && ad_dev_oe); endproperty
	property p_dev_cs; ad_dev_oe |-> cs_hi_reg < 3'h5; endproperty
	property p_wr_len; $fell(wr_n) |-> s_wr_held; endproperty
	property p_ds_len; $fell(data_strobe_n) |-> s_ds_held; endproperty
	property p_cs_len; $fell(cs_n) |-> s_cs_held; endproperty
	property p_strobe_cs; (!wr_n || !data_strobe_n) |-> !cs_n; endproperty
	property p_ale_addr; $rose(ale) |-> cs_n; endproperty
	property p_wr_data; (!wr_n && $past(!wr_n)) |-> $stable(ad); endproperty
	a_one_driver: assert property (p_one_driver) else $error("both ends drive data lines");
	a_dev_cs: assert property (p_dev_cs) else $error("device drives while deselected");
	a_wr_len: assert property (p_wr_len) else $error("write strobe too short");
	a_ds_len: assert property (p_ds_len) else $error("data strobe too short");
	a_cs_len: assert property (p_cs_len) else $error("select too short");
	a_strobe_cs: assert property (p_strobe_cs) else $error("strobe without select");
	a_ale_addr: assert property (p_ale_addr) else $error("latch pulse while selected");
	a_wr_data: assert property (p_wr_data) else $error("write data moved");
endmodule

// >>> testbench/dual_mode_host_bus_port_test.sv
`timescale 1ns/10ps
module dual_mode_host_bus_port_test;
	import host_port_pkg::*;
	logic        mclk_i = 1'b0;      // clock
	logic        rst_n_i = 1'b0;     // reset
	logic        psel = 1'b0;        // apb select
	logic        penable = 1'b0;     // apb enable
	logic        pwrite = 1'b0;      // apb direction
	logic [11:0] paddr = 12'h000;    // apb address
	logic [31:0] pwdata = 32'h0;     // apb write data
	logic        irq_event_i = 1'b0; // device event
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        irq_o;
	logic        soft_rst_o;
	logic [1:0]  style_o;
	logic [31:0] q;
	int          n_errors = 0;
	int          cmp_count = 0;
	int          cycles = 0;
	int          n_srst = 0;
	host_port_if u_host_port_if ();
	host_port_master u_host_port_master (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.irq_o(irq_o), .bus(u_host_port_if));
	host_port_device u_host_port_device (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus(u_host_port_if),
		.irq_event_i(irq_event_i), .soft_rst_o(soft_rst_o), .style_o(style_o));
	host_port_properties u_props (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cs_n(u_host_port_if.cs_n),
		.wr_n(u_host_port_if.wr_n), .data_strobe_n(u_host_port_if.data_strobe_n), .ale(u_host_port_if.ale),
		.ad_oe(u_host_port_if.ad_oe), .ad_dev_oe(u_host_port_if.ad_dev_oe), .ad(u_host_port_if.ad));
	// ----------------------------------------
	// clock, pulse count, hang guard
	// ----------------------------------------
	always #2 mclk_i = ~mclk_i;
	always @(posedge mclk_i) begin
		if (soft_rst_o === 1'b1)
			n_srst++;
		cycles++;
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task stop_test();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// one apb transfer, read data left in q
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk_i);
		penable <= 1'b1;
		@(posedge mclk_i);
		while (pready !== 1'b1) @(posedge mclk_i);
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// one device access, then poll until idle
	task cmd(input logic [7:0] a, input logic [7:0] d, input logic rd);
		int i;
		apb(1'b1, APB_CMD, {14'h0000, 1'b1, rd, d, a});
		for (i = 0; i < 200; i++) begin
			apb(1'b0, APB_STAT, 32'h0);
			if (q[0] === 1'b0)
				break;
		end
	endtask
	task pulse();
		@(posedge mclk_i);
		irq_event_i <= 1'b1;
		@(posedge mclk_i);
		irq_event_i <= 1'b0;
	endtask
	task hw_reset();
		rst_n_i <= 1'b0;
		repeat (16) @(posedge mclk_i);
		rst_n_i <= 1'b1;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_strobe();
		cmd(ADDR_IRQ_CTRL, 8'h04, 1'b0);
		apb(1'b1, APB_IMASK, 32'h2);
		pulse();
		cmd(ADDR_IRQ_CTRL, 8'h00, 1'b1);
		chk({31'h0, q[8+BIT_PENDING]}, 32'h1);
		chk({31'h0, u_host_port_if.int_n}, 32'h0);
		chk({30'h0, style_o}, {30'h0, STYLE_STROBE});
		chk({31'h0, irq_o}, 32'h1);
		apb(1'b0, APB_ISTAT, 32'h0);
		chk(q & 32'h3, 32'h3);
		apb(1'b0, APB_ISTAT, 32'h0);
		chk(q & 32'h1, 32'h0);
		apb(1'b1, APB_IMASK, 32'h0);
		@(posedge mclk_i);
		chk({31'h0, irq_o}, 32'h0);
		$display("t_strobe done");
	endtask
	task t_mux();
		apb(1'b1, APB_CFG, 32'h2);
		cmd(ADDR_IRQ_CTRL, 8'h00, 1'b0);
		cmd(ADDR_IRQ_CTRL, 8'h00, 1'b1);
		chk({31'h0, q[8+BIT_PENDING]}, 32'h0);
		chk({30'h0, style_o}, {30'h0, STYLE_MUX});
		pulse();
		cmd(ADDR_IRQ_CTRL, 8'h00, 1'b1);
		chk({31'h0, q[8+BIT_PENDING]}, 32'h1);
		chk({31'h0, u_host_port_if.int_n}, 32'h1);
		apb(1'b1, APB_CFG, 32'h0);
		cmd(ADDR_SOFT_RESET, 8'h00, 1'b1);
		chk({30'h0, style_o}, {30'h0, STYLE_MUX});
		$display("t_mux done");
	endtask
	task t_soft();
		cmd(ADDR_IRQ_CTRL, 8'h04, 1'b0);
		chk({30'h0, style_o}, {30'h0, STYLE_STROBE});
		pulse();
		cmd(ADDR_SOFT_RESET, 8'h01, 1'b0);
		cmd(ADDR_SOFT_RESET, 8'h00, 1'b1);
		chk({31'h0, q[8+BIT_SOFT_RESET]}, 32'h1);
		chk({31'h0, u_host_port_if.int_n}, 32'h0);
		cmd(ADDR_SOFT_RESET, 8'h00, 1'b0);
		chk(n_srst, 32'h1);
		cmd(ADDR_IRQ_CTRL, 8'h00, 1'b1);
		chk({31'h0, q[8+BIT_PENDING]}, 32'h0);
		chk({31'h0, u_host_port_if.int_n}, 32'h1);
		$display("t_soft done");
	endtask
	initial begin
		hw_reset();
		t_strobe();
		t_mux();
		hw_reset();
		t_soft();
		stop_test();
	end
endmodule
